// *** core/sfwp_consts.vh ***
// Constants for the serial flash write-protect block.
`ifndef SFWP_CONSTS_VH
`define SFWP_CONSTS_VH
// Status register one bit positions.
`define SFWP_S1_BUSY        0
`define SFWP_S1_WEL         1
`define SFWP_S1_BP_LO       2
`define SFWP_S1_BP_HI       5
`define SFWP_S1_TB          6
`define SFWP_S1_SRP         7
// Reset values of the writable protect fields.
`define SFWP_BP_RST         4'h0
`define SFWP_TB_RST         1'b0
`define SFWP_CMP_RST        1'b0
`define SFWP_SRP_RST        1'b0
`define SFWP_SRL_RST        1'b0
`define SFWP_WPS_RST        1'b0
// Command codes.
`define SFWP_CMD_WREN       8'h06
`define SFWP_CMD_WRDI       8'h04
`define SFWP_CMD_RDSR1      8'h05
`define SFWP_CMD_WRSR1      8'h01
`define SFWP_CMD_WRSR2      8'h31
`define SFWP_CMD_WRSR3      8'h11
`define SFWP_CMD_PP         8'h02
`define SFWP_CMD_QPP        8'h32
`define SFWP_CMD_SE         8'h20
`define SFWP_CMD_BE32       8'h52
`define SFWP_CMD_BE64       8'hd8
`define SFWP_CMD_CE         8'hc7
`define SFWP_CMD_ERSEC      8'h44
`define SFWP_CMD_PGSEC      8'h42
`define SFWP_CMD_SUSP       8'h75
`define SFWP_CMD_RESUME     8'h7a
`define SFWP_CMD_PD         8'hb9
`define SFWP_CMD_RPD        8'hab
`define SFWP_CMD_ULOCK      8'h39
`define SFWP_CMD_LOCK       8'h36
`define SFWP_CMD_GLOCK      8'h7e
`define SFWP_CMD_GULOCK     8'h98
// Lock array sizes.
`define SFWP_NUM_BLOCKS     2048
`define SFWP_NUM_MIDLOCKS   2044
`define SFWP_NUM_SECLOCKS   64
`define SFWP_NUM_LOCKS      2108
// Power-up write delay in microseconds, and its cycle count at 25 MHz.
`define SFWP_PUW_US         5000
`define SFWP_CLK_MHZ        25
`define SFWP_PUW_CYC        (`SFWP_PUW_US * `SFWP_CLK_MHZ)
`endif

// *** core/sfwp_sync.v ***
// Two flip-flop synchroniser for pin levels.
`timescale 1ns/1ps
`default_nettype none
module sfwp_sync #(
   parameter W = 1
) (
   // Clock and reset
   input  wire         clk,
   input  wire         rst_n,
   // Data
   input  wire [W-1:0] d,
   output reg  [W-1:0] q
);
   reg [W-1:0] meta_q;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= {W{1'b0}};
         q      <= {W{1'b0}};
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule // sfwp_sync
`default_nettype wire

// *** core/sfwp_top.v ***
// Write protection and status register one logic of a dual-die serial flash.
// Summary of operation
// RL1: Below inhibit voltage, hold reset, ignore everything.
// RL2: Reject write commands during power-up write delay.
// RL3: Write enable latch starts at zero.
// RL4: Writes need write enable latch set first.
// RL5: Completed program/erase/status write clears latch.
// RL6: Power-down ignores all but release.
// RL7: 2044 block locks plus 64 sector locks.
// RL8: Locked region drops program and erase.
// RL9: All individual locks set at power-on.
// RL10: Host unlocks region with individual unlock.
// RL11: Scheme select picks block-protect or individual locks.
// RL12: Status writes update both dies when idle.
// RL13: Status writes gated by protect bits, latch, pin.
// RL14: Busy bit reads one during operations.
// RL15: While busy, accept only status read, suspend.
// RL16: Latch sets on enable, clears on writes.
// RL17: Four block-protect bits, status write, default zero.
// RL18: Top/bottom bit chooses counting end.
// RL19: Complement bit inverts chosen protection region.
// RL20: Protect bit with low pin blocks status writes outside quad mode.
// RL21: Drop program/erase aimed at protected region.
`timescale 1ns/1ps
`default_nettype none
`include "sfwp_consts.vh"
module sfwp_top #(
   parameter PUW_CYCLES = `SFWP_PUW_CYC
) (
   // Clock and reset
   input  wire        clk,
   input  wire        rst_n,
   // Supply monitor, high while supply is below the inhibit level
   input  wire        write_inhibit_voltage,
   // Decoded command strobe from the serial front end
   input  wire        cmd_valid,
   input  wire [7:0]  cmd_code,
   input  wire [26:0] cmd_addr,
   input  wire [7:0]  cmd_sr1,
   input  wire [7:0]  cmd_sr2,
   input  wire [7:0]  cmd_sr3,
   // Pins
   input  wire        wp_n,
   input  wire        quad_mode,
   // Array engine of this die and the other die
   input  wire        op_done,
   input  wire        other_die_busy,
   // Results
   output reg         op_start_q,
   output reg  [7:0]  op_code_q,
   output reg  [26:0] op_addr_q,
   output reg         cmd_dropped_q,
   output reg  [7:0]  status_one_q,
   output reg         status_protect_bit_q,
   output reg         status_lockdown_bit_q,
   output reg         complement_protect_q,
   output reg         paused_op_flag_q,
   output reg         protect_scheme_select_q,
   output reg         powered_down_q
);
   localparam ST_INHIBIT = 2'd0;
   localparam ST_PUW     = 2'd1;
   localparam ST_READY   = 2'd2;

   wire wp_n_s;
   wire vwi_s;
   sfwp_sync #(.W(2)) u_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .d     ({wp_n, write_inhibit_voltage}),
      .q     ({wp_n_s, vwi_s})
   );

   reg  [1:0]  pwr_state_q;
   reg  [22:0] puw_cnt_q;
   reg         wel_q;
   reg         busy_q;
   reg  [3:0]  bp_q;
   reg         tb_q;
   reg         pd_q;
   reg  [`SFWP_NUM_LOCKS-1:0] lock_q;

   // Command classes.
   reg is_prog;
   reg is_erase;
   reg is_sec;
   reg is_srw;
   reg is_ce;
   always @* begin
      is_prog  = (cmd_code == `SFWP_CMD_PP) || (cmd_code == `SFWP_CMD_QPP);
      is_erase = (cmd_code == `SFWP_CMD_SE) || (cmd_code == `SFWP_CMD_BE32) ||
                 (cmd_code == `SFWP_CMD_BE64) || (cmd_code == `SFWP_CMD_CE);
      is_ce    = (cmd_code == `SFWP_CMD_CE);
      is_sec   = (cmd_code == `SFWP_CMD_ERSEC) || (cmd_code == `SFWP_CMD_PGSEC);
      is_srw   = (cmd_code == `SFWP_CMD_WRSR1) || (cmd_code == `SFWP_CMD_WRSR2) ||
                 (cmd_code == `SFWP_CMD_WRSR3);
   end

   // Lock index: the end blocks of each die use sector locks, so no two
   // regions share a lock bit.
   wire [10:0] blk      = cmd_addr[26:16];
   wire [3:0]  sec      = cmd_addr[15:12];
   wire        blk_end  = (blk[9:0] == 10'h000) || (blk[9:0] == 10'h3ff);
   reg  [11:0] lock_idx;
   always @* begin
      if (blk_end) begin
         lock_idx = 12'd2044 + {6'h00, blk[10], blk[9], sec};       // see RL7
      end else if (blk[10]) begin
         lock_idx = {2'b00, blk[9:0]} + 12'd1021;                    // see RL7
      end else begin
         lock_idx = {2'b00, blk[9:0]} - 12'd1;
      end
   end

   // Block-protect range: level n protects 2^(n-1) blocks from one end, all 2048 from level 12 up.
   reg [11:0] bp_span;
   reg        bp_in;
   reg        bp_prot;
   always @* begin
      bp_span = (bp_q == 4'h0) ? 12'd0 :
                (bp_q >= 4'hc) ? 12'd2048 : (12'd1 << (bp_q - 4'h1));
      if (tb_q) begin
         bp_in = ({1'b0, blk} < bp_span); // see RL18
      end else begin
         bp_in = ({1'b0, blk} >= (12'd2048 - bp_span)) && (bp_span != 12'd0);
      end
      bp_prot = bp_in ^ complement_protect_q; // see RL19
   end

   wire any_lock   = |lock_q;
   wire any_bp     = complement_protect_q ? (bp_span != 12'd2048) : (bp_span != 12'd0);
   wire region_lk  = lock_q[lock_idx];
   wire protected_hit = protect_scheme_select_q ?                 // see RL11
                        (is_ce ? any_lock : region_lk) :          // see RL8
                        (is_ce ? any_bp : bp_prot);               // see RL17

   // Status write gate from the protect bits, the latch and the pin.
   wire pin_lock   = status_protect_bit_q && !wp_n_s && !quad_mode;  // see RL20
   wire srw_ok     = wel_q && !status_lockdown_bit_q && !pin_lock && // see RL13
                     !other_die_busy;                                // see RL12
   wire ready      = (pwr_state_q == ST_READY);
   wire accept     = cmd_valid && (pwr_state_q != ST_INHIBIT);       // see RL1
   wire write_cmd  = (cmd_code == `SFWP_CMD_WREN) || is_prog || is_erase ||
                     is_sec || is_srw;
   wire gated_busy = busy_q && (cmd_code != `SFWP_CMD_RDSR1) &&
                     (cmd_code != `SFWP_CMD_SUSP);                   // see RL15
   wire gated_pd   = pd_q && (cmd_code != `SFWP_CMD_RPD);            // see RL6
   wire gated_puw  = !ready && write_cmd;                            // see RL2
   wire live       = accept && !gated_busy && !gated_pd && !gated_puw;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pwr_state_q             <= ST_INHIBIT;
         puw_cnt_q               <= 23'd0;
         wel_q                   <= 1'b0;
         busy_q                  <= 1'b0;
         bp_q                    <= `SFWP_BP_RST;
         tb_q                    <= `SFWP_TB_RST;
         pd_q                    <= 1'b0;
         lock_q                  <= {`SFWP_NUM_LOCKS{1'b1}};
         op_start_q              <= 1'b0;
         op_code_q               <= 8'h00;
         op_addr_q               <= 27'd0;
         cmd_dropped_q           <= 1'b0;
         status_one_q            <= 8'h00;
         status_protect_bit_q    <= `SFWP_SRP_RST;
         status_lockdown_bit_q   <= `SFWP_SRL_RST;
         complement_protect_q    <= `SFWP_CMP_RST;
         paused_op_flag_q        <= 1'b0;
         protect_scheme_select_q <= `SFWP_WPS_RST;
         powered_down_q          <= 1'b0;
      end else if (vwi_s) begin
         // Supply dip: return to the power-on state, except op_code_q and op_addr_q, and accept nothing.
         pwr_state_q             <= ST_INHIBIT;                      // see RL1
         puw_cnt_q               <= 23'd0;
         wel_q                   <= 1'b0;                            // see RL3
         busy_q                  <= 1'b0;
         bp_q                    <= `SFWP_BP_RST;
         tb_q                    <= `SFWP_TB_RST;
         pd_q                    <= 1'b0;
         lock_q                  <= {`SFWP_NUM_LOCKS{1'b1}};         // see RL9
         op_start_q              <= 1'b0;
         cmd_dropped_q           <= 1'b0;
         status_one_q            <= 8'h00;
         status_protect_bit_q    <= `SFWP_SRP_RST;
         status_lockdown_bit_q   <= `SFWP_SRL_RST;
         complement_protect_q    <= `SFWP_CMP_RST;
         paused_op_flag_q        <= 1'b0;
         protect_scheme_select_q <= `SFWP_WPS_RST;
         powered_down_q          <= 1'b0;
      end else begin
         op_start_q    <= 1'b0;
         cmd_dropped_q <= 1'b0;
         case (pwr_state_q)
            ST_INHIBIT: begin
               pwr_state_q <= ST_PUW;
               puw_cnt_q   <= 23'd0;
            end
            ST_PUW: begin
               if (puw_cnt_q >= PUW_CYCLES[22:0] - 23'd1) begin     // see RL2
                  pwr_state_q <= ST_READY;
               end else begin
                  puw_cnt_q <= puw_cnt_q + 23'd1;
               end
            end
            ST_READY: begin
               pwr_state_q <= ST_READY;
            end
            default: begin
               pwr_state_q <= ST_INHIBIT;
            end
         endcase
         // Completion of an array or status operation.
         if (busy_q && op_done) begin
            busy_q <= 1'b0;                                          // see RL14
            wel_q  <= 1'b0;                                          // see RL5
         end
         if (cmd_valid && !live) begin
            cmd_dropped_q <= 1'b1;
         end
         if (live) begin
            case (cmd_code)
               `SFWP_CMD_WREN:   wel_q <= 1'b1;                      // see RL16
               `SFWP_CMD_WRDI:   wel_q <= 1'b0;                      // see RL16
               `SFWP_CMD_PD:     pd_q  <= 1'b1;
               `SFWP_CMD_RPD:    pd_q  <= 1'b0;
               `SFWP_CMD_SUSP: begin
                  if (busy_q) begin
                     busy_q           <= 1'b0;
                     paused_op_flag_q <= 1'b1;
                  end
               end
               `SFWP_CMD_RESUME: begin
                  if (paused_op_flag_q) begin
                     busy_q           <= 1'b1;
                     paused_op_flag_q <= 1'b0;
                  end
               end
               `SFWP_CMD_ULOCK:  lock_q[lock_idx] <= 1'b0;
               `SFWP_CMD_LOCK:   lock_q[lock_idx] <= 1'b1;
               `SFWP_CMD_GLOCK:  lock_q <= {`SFWP_NUM_LOCKS{1'b1}};
               `SFWP_CMD_GULOCK: lock_q <= {`SFWP_NUM_LOCKS{1'b0}};
               default: begin
                  if (is_srw) begin
                     if (srw_ok) begin
                        // Both dies take the same value in the same cycle.
                        wel_q  <= 1'b0;                              // see RL16
                        busy_q <= 1'b1;                              // see RL14
                        op_start_q <= 1'b1;
                        op_code_q  <= cmd_code;
                        if (cmd_code == `SFWP_CMD_WRSR1) begin
                           bp_q <= cmd_sr1[`SFWP_S1_BP_HI:`SFWP_S1_BP_LO]; // see RL17
                           tb_q <= cmd_sr1[`SFWP_S1_TB];
                           status_protect_bit_q <= cmd_sr1[`SFWP_S1_SRP];
                        end else if (cmd_code == `SFWP_CMD_WRSR2) begin
                           status_lockdown_bit_q <= cmd_sr2[0];
                           complement_protect_q  <= cmd_sr2[6];
                        end else begin
                           protect_scheme_select_q <= cmd_sr3[2];
                        end
                     end else begin
                        cmd_dropped_q <= 1'b1;                       // see RL13
                     end
                  end else if (is_prog || is_erase || is_sec) begin
                     if (!wel_q) begin
                        cmd_dropped_q <= 1'b1;                       // see RL4
                     end else if (!is_sec && protected_hit) begin
                        cmd_dropped_q <= 1'b1;                       // see RL21
                     end else begin
                        wel_q      <= 1'b0;                          // see RL16
                        busy_q     <= 1'b1;                          // see RL14
                        op_start_q <= 1'b1;
                        op_code_q  <= cmd_code;
                        op_addr_q  <= cmd_addr;
                     end
                  end
               end
            endcase
         end
         powered_down_q <= pd_q;
         status_one_q   <= {status_protect_bit_q, tb_q, bp_q, wel_q, busy_q};
      end
   end
endmodule // sfwp_top
`default_nettype wire

// *** verification/sfwp_top_props.sv ***
// Concurrent checks on the ports of the write-protect block.
`timescale 1ns/1ps
`default_nettype none
`include "sfwp_consts.vh"
module sfwp_top_props #(
   parameter PUW_CYCLES = 10
) (
   // Clock, reset and inputs
   input wire logic       clk, rst_n, write_inhibit_voltage, cmd_valid, wp_n, quad_mode,
   input wire logic       op_done, other_die_busy,
   input wire logic [7:0] cmd_code,
   // Outputs
   input wire logic       op_start_q, cmd_dropped_q, status_protect_bit_q, status_lockdown_bit_q,
   input wire logic       powered_down_q,
   input wire logic [7:0] op_code_q, status_one_q
);
   default clocking cb @(posedge clk); endclocking
   logic [1:0]  hold_q;
   logic [31:0] up_q;
   // The design still ignores commands while its supply synchroniser drains.
   default disable iff (!rst_n || write_inhibit_voltage || hold_q != 2'h0);
   wire         wr_op = op_code_q inside {8'h02, 8'h32, 8'h20, 8'h52, 8'hd8, 8'hc7, 8'h44, 8'h42};
   wire         wrsr1 = cmd_valid && cmd_code == `SFWP_CMD_WRSR1;
   // Cycles since reset or since a supply dip ended, so the power-up write window can be judged.
   always @(posedge clk or negedge rst_n)
      if (!rst_n) hold_q <= 2'h0;
      else if (write_inhibit_voltage) hold_q <= 2'h3;
      else if (hold_q != 2'h0) hold_q <= hold_q - 2'h1;
   always @(posedge clk or negedge rst_n)
      if (!rst_n) up_q <= 32'h0;
      else if (write_inhibit_voltage || hold_q != 2'h0) up_q <= 32'h0;
      else if (up_q < 32'hffff) up_q <= up_q + 32'h1;
   a_start_drop_excl: assert property (!(op_start_q && cmd_dropped_q))
      else $error("start and drop together");
   a_puw_drops_wren: assert property (cmd_valid && cmd_code == `SFWP_CMD_WREN &&
      up_q < PUW_CYCLES |-> ##1 cmd_dropped_q) else $error("enable taken in power-up delay");
   a_pd_ignores_cmds: assert property (cmd_valid && cmd_code != `SFWP_CMD_RPD ##1
      powered_down_q |-> cmd_dropped_q) else $error("command taken in power-down");
   a_wel_needed_first: assert property ((!cmd_valid)[*2] ##1 (cmd_valid &&
      cmd_code == `SFWP_CMD_PP && !status_one_q[1]) |-> ##1 cmd_dropped_q)
      else $error("program taken without enable");
   a_op_clears_wel: assert property (op_start_q && wr_op |-> ##1 status_one_q[1:0] == 2'b01)
      else $error("busy or latch wrong after launch");
   a_busy_refuses_cmd: assert property ((!op_done && !cmd_valid)[*2] ##1 (cmd_valid &&
      !op_done && cmd_code == `SFWP_CMD_WREN && status_one_q[0]) |-> ##1 cmd_dropped_q)
      else $error("enable taken while busy");
   a_done_clears_busy: assert property (op_done && !cmd_valid |-> ##2 !status_one_q[0])
      else $error("busy stays after completion");
   a_lockdown_blocks: assert property (wrsr1 && status_lockdown_bit_q |-> ##1 cmd_dropped_q)
      else $error("status write taken under lock-down");
   a_pin_blocks_wrsr: assert property ((!wp_n)[*3] ##0 (wrsr1 && status_protect_bit_q &&
      !quad_mode) |-> ##1 cmd_dropped_q) else $error("status write taken with pin low");
   a_other_die_busy: assert property (wrsr1 && other_die_busy |-> ##1 cmd_dropped_q)
      else $error("status write taken with other die busy");
   c_op_start: cover property (op_start_q);
   c_pd_drop: cover property (powered_down_q && cmd_dropped_q);
   c_srp_set: cover property ($rose(status_protect_bit_q));
endmodule // sfwp_top_props
`default_nettype wire

// *** verification/sfwp_engine_model.sv ***
// Array engine model that finishes each launched operation after a chosen delay.
`timescale 1ns/1ps
`default_nettype none
module sfwp_engine_model (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Launch and delay
   input  wire logic       op_start_q,
   input  wire logic [7:0] lat,
   // Completion
   output var  logic       op_done
);
   logic [7:0] cnt_q;
   logic       run_q;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         run_q <= 1'b0;
         cnt_q <= 8'h00;
         op_done <= 1'b0;
      end else begin
         op_done <= 1'b0;
         if (op_start_q) begin
            run_q <= 1'b1;
            cnt_q <= lat;
         end else if (run_q && cnt_q == 8'h00) begin
            run_q <= 1'b0;
            op_done <= 1'b1;
         end else if (run_q) cnt_q <= cnt_q - 8'h01;
      end
   end
endmodule // sfwp_engine_model
`default_nettype wire

// *** verification/sfwp_top_tb.sv ***
// Self-checking testbench for the serial flash write-protect block.
`timescale 1ns/1ps
`default_nettype none
`include "sfwp_consts.vh"
module sfwp_top_tb;
   localparam int PUW = 10;
   logic        clk = 0, rst_n = 0, inh = 0, cmd_valid = 0, wp_n = 1, quad_mode = 0, odb = 0;
   logic [7:0]  cmd_code = 0, d_q = 0, lat = 8'h03;
   logic [26:0] cmd_addr = 0, a;
   logic        st, dr;
   int          fail_count = 0, compares = 0, i;
   wire         op_done, op_start_q, cmd_dropped_q, status_protect_bit, status_lockdown_bit, cmp, paused, protect_scheme_select, pd;
   wire [7:0]   op_code_q, status_one_q;
   wire [26:0]  op_addr_q;
   always #20 clk = ~clk;
   sfwp_top #(.PUW_CYCLES(PUW)) u_sfwp_top (.clk(clk), .rst_n(rst_n), .write_inhibit_voltage(inh),
      .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_addr(cmd_addr), .cmd_sr1(d_q),
      .cmd_sr2(d_q), .cmd_sr3(d_q), .wp_n(wp_n), .quad_mode(quad_mode), .op_done(op_done),
      .other_die_busy(odb), .op_start_q(op_start_q), .op_code_q(op_code_q), .op_addr_q(op_addr_q),
      .cmd_dropped_q(cmd_dropped_q), .status_one_q(status_one_q), .status_protect_bit_q(status_protect_bit),
      .status_lockdown_bit_q(status_lockdown_bit), .complement_protect_q(cmp), .paused_op_flag_q(paused),
      .protect_scheme_select_q(protect_scheme_select), .powered_down_q(pd));
   sfwp_engine_model u_sfwp_engine_model (.clk(clk), .rst_n(rst_n), .op_start_q(op_start_q),
      .lat(lat), .op_done(op_done));
   function automatic [7:0] sr1_e(input [3:0] bp, input tb, srp_b, write_enable_latch, busy);
      return {srp_b, tb, bp, write_enable_latch, busy};
   endfunction
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task cmd(input [7:0] c, input [26:0] ad, input [7:0] d);
      @(posedge clk);
      cmd_valid <= 1'b1; cmd_code <= c; cmd_addr <= ad; d_q <= d;
      @(posedge clk);
      cmd_valid <= 1'b0;
      #1 st = op_start_q; dr = cmd_dropped_q;
      @(posedge clk);
      #1;
   endtask
   // This task enables writing right before the write-class command it sends.
   task wr(input [7:0] c, input [26:0] ad, input [7:0] d);
      cmd(`SFWP_CMD_WREN, 27'h0, 8'h00);
      cmd(c, ad, d);
   endtask
   task idle;
      int k;
      for (k = 0; k < 300 && status_one_q[0] !== 1'b0; k++) begin
         @(posedge clk);
         #1;
      end
      chk("busy end", 0, status_one_q[0]);
   endtask
   task conclude;
      $display("Comparisons %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      conclude();
   end
   initial begin
      void'($urandom(32'h1175edff));
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      #1;
      chk("sr1 reset", sr1_e(4'h0, 0, 0, 0, 0), status_one_q);
      chk("cmp wps srl", 0, {cmp, protect_scheme_select, status_lockdown_bit, pd});
      cmd(`SFWP_CMD_WREN, 27'h0, 8'h00);
      chk("puw drop", 1, dr);
      repeat (PUW + 4) @(posedge clk);
      cmd(`SFWP_CMD_PP, 27'h100, 8'h00);
      chk("pp no wel", 1, dr);
      cmd(`SFWP_CMD_WREN, 27'h0, 8'h00);
      chk("wel set", 1, status_one_q[1]);
      cmd(`SFWP_CMD_WRDI, 27'h0, 8'h00);
      chk("wel clear", 0, status_one_q[1]);
      $display("Test latch done");
      for (i = 0; i < 4; i++) begin
         a = 27'($urandom);
         lat <= 8'($urandom_range(1, 20));
         wr(`SFWP_CMD_PP, a, 8'h00);
         chk("pp start", 1, st);
         chk("pp addr", a, op_addr_q);
         chk("pp code", `SFWP_CMD_PP, op_code_q);
         chk("sr1 busy", sr1_e(4'h0, 0, 0, 0, 1), status_one_q);
         idle();
      end
      lat <= 8'd60;
      wr(`SFWP_CMD_SE, a, 8'h00);
      cmd(`SFWP_CMD_WREN, 27'h0, 8'h00);
      chk("busy wren", 1, dr);
      cmd(`SFWP_CMD_RDSR1, 27'h0, 8'h00);
      chk("busy rdsr", 0, dr);
      cmd(`SFWP_CMD_SUSP, 27'h0, 8'h00);
      chk("suspend", 2'b10, {paused, status_one_q[0]});
      cmd(`SFWP_CMD_RESUME, 27'h0, 8'h00);
      chk("resume", 2'b01, {paused, status_one_q[0]});
      idle();
      lat <= 8'd4;
      $display("Test busy done");
      wr(`SFWP_CMD_WRSR1, 27'h0, 8'h3c);
      idle();
      chk("bp all", 4'hf, status_one_q[5:2]);
      wr(`SFWP_CMD_PP, a, 8'h00);
      chk("bp drop", 1, dr);
      wr(`SFWP_CMD_WRSR2, 27'h0, 8'h40);
      idle();
      chk("cmp set", 1, cmp);
      wr(`SFWP_CMD_PP, a, 8'h00);
      chk("cmp start", 1, st);
      idle();
      wr(`SFWP_CMD_WRSR1, 27'h0, 8'h44);
      idle();
      chk("tb set", sr1_e(4'h1, 1, 0, 0, 0), status_one_q);
      wr(`SFWP_CMD_PP, 27'h0, 8'h00);
      chk("tb bottom", 1, st);
      idle();
      wr(`SFWP_CMD_PP, 27'h7ff0000, 8'h00);
      chk("tb top", 1, dr);
      wr(`SFWP_CMD_WRSR2, 27'h0, 8'h00);
      idle();
      $display("Test block protect done");
      wr(`SFWP_CMD_WRSR3, 27'h0, 8'h04);
      idle();
      chk("wps set", 1, protect_scheme_select);
      for (i = 0; i < 3; i++) begin
         a = 27'($urandom);
         wr(`SFWP_CMD_PP, a, 8'h00);
         chk("lock drop", 1, dr);
         wr(`SFWP_CMD_ULOCK, a, 8'h00);
         idle();
         wr(`SFWP_CMD_PP, a, 8'h00);
         chk("unlock start", 1, st);
         idle();
         wr(`SFWP_CMD_SE, a ^ 27'h0400000, 8'h00);
         chk("other block", 1, dr);
      end
      cmd(`SFWP_CMD_GULOCK, 27'h0, 8'h00);
      wr(`SFWP_CMD_PP, a ^ 27'h0400000, 8'h00);
      chk("global unlock", 1, st);
      idle();
      cmd(`SFWP_CMD_GLOCK, 27'h0, 8'h00);
      wr(`SFWP_CMD_PP, a, 8'h00);
      chk("global lock", 1, dr);
      wr(`SFWP_CMD_WRSR3, 27'h0, 8'h00);
      idle();
      $display("Test individual locks done");
      wr(`SFWP_CMD_WRSR1, 27'h0, 8'h80);
      idle();
      @(posedge clk) wp_n <= 1'b0;
      wr(`SFWP_CMD_WRSR1, 27'h0, 8'h80);
      chk("pin drop", 1, dr);
      @(posedge clk) quad_mode <= 1'b1;
      wr(`SFWP_CMD_WRSR1, 27'h0, 8'h00);
      chk("quad write", 0, dr);
      idle();
      chk("srp clear", 0, status_protect_bit);
      @(posedge clk) begin
         wp_n <= 1'b1;
         quad_mode <= 1'b0;
         odb <= 1'b1;
      end
      wr(`SFWP_CMD_WRSR1, 27'h0, 8'h00);
      chk("die busy", 1, dr);
      @(posedge clk) odb <= 1'b0;
      $display("Test status gating done");
      cmd(`SFWP_CMD_PD, 27'h0, 8'h00);
      chk("pd set", 1, pd);
      cmd(`SFWP_CMD_WREN, 27'h0, 8'h00);
      chk("pd drop", 1, dr);
      cmd(`SFWP_CMD_RPD, 27'h0, 8'h00);
      chk("pd release", 0, {dr, pd});
      cmd(`SFWP_CMD_WREN, 27'h0, 8'h00);
      @(posedge clk) inh <= 1'b1;
      repeat (4) @(posedge clk);
      inh <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
      chk("inhibit wel", 0, status_one_q[1]);
      cmd(`SFWP_CMD_WREN, 27'h0, 8'h00);
      chk("inhibit puw", 1, dr);
      repeat (PUW + 4) @(posedge clk);
      wr(`SFWP_CMD_WRSR2, 27'h0, 8'h01);
      idle();
      wr(`SFWP_CMD_WRSR1, 27'h0, 8'h3c);
      chk("lockdown", 2'b11, {status_lockdown_bit, dr});
      $display("Test power and lock-down done");
      conclude();
   end
endmodule // sfwp_top_tb
bind sfwp_top sfwp_top_props #(.PUW_CYCLES(PUW_CYCLES)) u_sfwp_top_props (.clk(clk),
   .rst_n(rst_n), .write_inhibit_voltage(write_inhibit_voltage), .cmd_valid(cmd_valid),
   .wp_n(wp_n), .quad_mode(quad_mode), .op_done(op_done), .other_die_busy(other_die_busy),
   .cmd_code(cmd_code), .op_start_q(op_start_q), .cmd_dropped_q(cmd_dropped_q),
   .status_protect_bit_q(status_protect_bit_q), .status_lockdown_bit_q(status_lockdown_bit_q),
   .powered_down_q(powered_down_q), .op_code_q(op_code_q), .status_one_q(status_one_q));
`default_nettype wire
